// ### rtl/multiport_core_memory_control.sv
// Arbitration, address match, cycle timing and panel logic of a core memory unit
`timescale 1ns/100ps

// Overview of operation
// - Two controllers; 22 or 18 bit addresses
// - Cycle 1000/1180 ns, 64K/128K words per module
// - Without error stop, drop incomplete cycle
// - Error stop halts on restart, parity, control errors
// - Reset switch releases a halted unit
// - Single cycle: one cycle per reset
// - Request after stop still acked, then hangs
// - Reset lets hung cycle finish
// - Display select, freeze and release of latches
// - Four half-module banks, deselectable, shown in use
// - Local setting disconnects unit from all ports
// - Per port: deselected, short or long address
// - Three priority groups in fixed order
// - Two-port groups alternate after each grant
// - Four-port ring, top passes on grant
// - Short-address ports ignore bits 14-17
// - Memory number sets lower bound, skip deselected banks
// - Bits 19,20 not matched, only pick the bank; bit 18 conditional
// - Bit-35 interleave: even ctl 0, odd ctl 1
// - Both interleaves: answer parity of memory number
module multiport_core_memory_control (
  // Clock, reset, enable
  input  wire logic                            clk,
  input  wire logic                            resetn,
  input  wire logic                            ce,
  // Wishbone slave
  input  wire logic                            wbCyc,
  input  wire logic                            wbStb,
  input  wire logic                            wbWe,
  input  wire logic [7:0]                      wbAdr,
  input  wire logic [3:0]                      wbSel,
  input  wire logic [31:0]                     wbDatI,
  output logic      [31:0]                     wbDatO,
  output logic                                 wbAck,
  // Processor ports
  input  wire logic [core_mem_pkg::NPORTS-1:0] portReq,
  input  wire logic [core_mem_pkg::NPORTS-1:0] portWrite,
  input  wire logic [core_mem_pkg::NPORTS-1:0] portWrRestart,
  input  wire logic [8*core_mem_pkg::ADDR_W-1:0] portAddr,
  output logic      [core_mem_pkg::NPORTS-1:0] portAck,
  output logic      [core_mem_pkg::NPORTS-1:0] portRdDone,
  // Storage modules
  input  wire logic                            parityErr,
  input  wire logic                            ctlErr,
  input  wire logic [core_mem_pkg::BUF_W-1:0]  bufIn,
  output logic      [1:0]                      memStart,
  output logic      [1:0]                      memBank,
  output logic                                 memWrite,
  output logic      [core_mem_pkg::ADDR_W-1:0] memAddr,
  // Indicators
  output logic      [core_mem_pkg::ADDR_W-1:0] dispAddr,
  output logic      [core_mem_pkg::BUF_W-1:0]  dispBuf,
  output logic      [3:0]                      banksInUse,
  output logic      [core_mem_pkg::NPORTS-1:0] portActive,
  output logic      [core_mem_pkg::NPORTS-1:0] portReqLamp
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NP = core_mem_pkg::NPORTS;
  localparam int AW = core_mem_pkg::ADDR_W;

  core_mem_pkg::state_t state_r;
  logic [31:0]     ctrl_r;
  logic [31:0]     portCfg_r;
  logic            resetPulse_r;
  logic            releasePulse_r;
  logic            frozen_r;
  logic            stop_r;
  logic            incFlag_r;
  logic            parFlag_r;
  logic            ctlFlag_r;
  logic [8:0]      cnt_r;
  logic [2:0]      curPort_r;
  logic            curWrite_r;
  logic [1:0]      curBank_r;
  logic [AW-1:0]   curAddr_r;
  logic            pairA_r;
  logic            pairB_r;
  logic [1:0]      ringTop_r;
  logic [AW-1:0]   latAddr_r [2];
  logic [core_mem_pkg::BUF_W-1:0] latBuf_r [2];
  logic [NP-1:0]   selMask;
  logic [NP-1:0]   elig;
  logic [1:0]      bankOf [NP];
  logic [3:0]      bankEn;
  logic            gntValid;
  logic [2:0]      gntIdx;
  logic            hold;
  logic [8:0]      cycLen;
  logic            wbReq;
  logic [6:0]      memNum;

  assign hold   = ctrl_r[core_mem_pkg::F_SINGLE] && stop_r;
  assign cycLen = ctrl_r[core_mem_pkg::F_BIG] ? core_mem_pkg::CYC_BIG
                                              : core_mem_pkg::CYC_SMALL;
  assign wbReq  = wbCyc && wbStb && !wbAck;
  assign memNum = ctrl_r[core_mem_pkg::F_MEMNUM +: 7];

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte-lane merge of a Wishbone write
  function automatic logic [31:0] laneMerge(logic [31:0] old, logic [31:0] d,
                                            logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Nth enabled bank of a mask: {found, bank}
  function automatic logic [2:0] pickBank(logic [3:0] en, logic [1:0] n);
    logic [2:0] r;
    logic [2:0] cnt;
    r   = 3'h0;
    cnt = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        if (cnt == {1'b0, n} && !r[2]) begin
          r = {1'b1, 2'(i)};
        end
        cnt = cnt + 3'h1;
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Address match per port
  // ----------------------------------------------------------------
  // Deselected banks and a missing second module shrink the unit
  always_comb begin
    bankEn = ~ctrl_r[core_mem_pkg::F_BANKDES +: 4];
    if (ctrl_r[core_mem_pkg::F_ONEMOD]) begin
      bankEn[3:2] = 2'h0;
    end
  end

  always_comb begin
    logic [AW-1:0] a;
    logic          hit;
    logic          use18;
    logic [1:0]    lb;
    logic [2:0]    pk;
    a     = '0;
    hit   = 1'b0;
    use18 = 1'b0;
    lb    = 2'h0;
    pk    = 3'h0;
    for (int p = 0; p < NP; p++) begin
      a = portAddr[p*AW +: AW];
      selMask[p] = portCfg_r[2*p +: 2] != core_mem_pkg::CFG_DESEL;
      use18 = !ctrl_r[core_mem_pkg::F_BIG] || ctrl_r[core_mem_pkg::F_ONEMOD]
              || (bankEn != 4'hf);
      hit = 1'b1;
      // Bits 14-17 only for long-address ports
      if (portCfg_r[2*p +: 2] == core_mem_pkg::CFG_LONG &&
          a[core_mem_pkg::IX_B14 -: 4] != memNum[6:3]) begin
        hit = 1'b0;
      end
      if (use18 && a[core_mem_pkg::IX_B18] != memNum[2]) begin
        hit = 1'b0;
      end
      // Logical bank from the bits below the unit number
      if (!use18) begin
        lb = {a[core_mem_pkg::IX_B18], a[core_mem_pkg::IX_B19]};
      end else if (ctrl_r[core_mem_pkg::F_BIG]) begin
        lb = {1'b0, a[core_mem_pkg::IX_B19]};
      end else begin
        lb = {a[core_mem_pkg::IX_B19], a[core_mem_pkg::IX_B20]};
      end
      if (ctrl_r[core_mem_pkg::F_INTL35]) begin
        // Word parity picks the controller
        pk = pickBank(bankEn & (a[core_mem_pkg::IX_B35] ? 4'hc : 4'h3),
                      {1'b0, lb[0]});
        if (ctrl_r[core_mem_pkg::F_INTL34] &&
            a[core_mem_pkg::IX_B35] != memNum[0]) begin
          hit = 1'b0;
        end
      end else begin
        pk = pickBank(bankEn, lb);
      end
      bankOf[p] = pk[1:0];
      elig[p]   = portReq[p] && selMask[p] && hit && pk[2] &&
                  !ctrl_r[core_mem_pkg::F_LOCAL];
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  // Group precedence keeps the pair groups from being starved by the ring
  always_comb begin
    logic [2:0] r;
    gntValid = 1'b0;
    gntIdx   = 3'h0;
    r        = 3'h0;
    if (elig[1:0] != 2'h0) begin
      gntValid = 1'b1;
      gntIdx   = (elig[1] && (pairA_r || !elig[0])) ? 3'h1 : 3'h0;
    end else if (elig[3:2] != 2'h0) begin
      gntValid = 1'b1;
      gntIdx   = (elig[3] && (pairB_r || !elig[2])) ? 3'h3 : 3'h2;
    end else begin
      for (int k = 3; k >= 0; k--) begin
        r = {1'b1, 2'(ringTop_r + 2'(k))};
        if (elig[r]) begin
          gntValid = 1'b1;
          gntIdx   = r;
        end
      end
    end
  end

  // Rotation state moves only when a grant is actually issued
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pairA_r   <= 1'b0;
      pairB_r   <= 1'b0;
      ringTop_r <= 2'h0;
    end else if (ce && state_r == core_mem_pkg::ST_IDLE && gntValid) begin
      if (gntIdx[2:1] == 2'h0) begin
        pairA_r <= !gntIdx[0];
      end
      if (gntIdx[2:1] == 2'h1) begin
        pairB_r <= !gntIdx[0];
      end
      if (gntIdx == {1'b1, ringTop_r}) begin
        ringTop_r <= ringTop_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= core_mem_pkg::ST_IDLE;
      cnt_r      <= 9'h0;
      curPort_r  <= 3'h0;
      curWrite_r <= 1'b0;
      curBank_r  <= 2'h0;
      curAddr_r  <= '0;
      portAck    <= '0;
      portRdDone <= '0;
      memStart   <= 2'h0;
      incFlag_r  <= 1'b0;
    end else if (ce) begin
      portAck    <= '0;
      portRdDone <= '0;
      memStart   <= 2'h0;
      if (resetPulse_r) begin
        incFlag_r <= 1'b0;
      end
      case (state_r)
        core_mem_pkg::ST_IDLE: begin
          // Grants go out even while stopped, so no port sees nonexistent memory
          if (gntValid) begin
            portAck[gntIdx] <= 1'b1;
            curPort_r  <= gntIdx;
            curWrite_r <= portWrite[gntIdx];
            curBank_r  <= bankOf[gntIdx];
            curAddr_r  <= portAddr[32'(gntIdx)*AW +: AW];
            cnt_r      <= 9'h0;
            if (portWrite[gntIdx]) begin
              state_r <= core_mem_pkg::ST_WRWAIT;
            end else begin
              state_r  <= core_mem_pkg::ST_CYCLE;
              memStart <= 2'h1 << bankOf[gntIdx][1];
            end
          end
        end
        core_mem_pkg::ST_WRWAIT: begin
          cnt_r <= cnt_r + 9'h1;
          if (portWrRestart[curPort_r]) begin
            state_r  <= core_mem_pkg::ST_CYCLE;
            memStart <= 2'h1 << curBank_r[1];
            cnt_r    <= 9'h0;
          end else if (hold && !resetPulse_r) begin
            cnt_r <= 9'h0;
          end else if (cnt_r == core_mem_pkg::WR_TIMEOUT) begin
            if (ctrl_r[core_mem_pkg::F_ERRSTOP]) begin
              state_r   <= core_mem_pkg::ST_HALT;
              incFlag_r <= 1'b1;
            end else begin
              state_r <= core_mem_pkg::ST_IDLE;
            end
          end
        end
        core_mem_pkg::ST_CYCLE: begin
          if (ctrl_r[core_mem_pkg::F_ERRSTOP] && (parityErr || ctlErr)) begin
            state_r <= core_mem_pkg::ST_HALT;
          end else if (!hold || resetPulse_r) begin
            cnt_r <= cnt_r + 9'h1;
            if (cnt_r == cycLen - 9'h1) begin
              state_r <= core_mem_pkg::ST_IDLE;
              portRdDone[curPort_r] <= !curWrite_r;
            end
          end
        end
        core_mem_pkg::ST_HALT: begin
          if (resetPulse_r) begin
            state_r <= core_mem_pkg::ST_IDLE;
          end
        end
        default: state_r <= core_mem_pkg::ST_IDLE;
      endcase
    end
  end

  // Stop flag of single-cycle mode; end of cycle wins over reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stop_r <= 1'b0;
    end else if (ce) begin
      if (state_r == core_mem_pkg::ST_CYCLE && (!hold || resetPulse_r) &&
          cnt_r == cycLen - 9'h1 && ctrl_r[core_mem_pkg::F_SINGLE]) begin
        stop_r <= 1'b1;
      end else if (resetPulse_r || !ctrl_r[core_mem_pkg::F_SINGLE]) begin
        stop_r <= 1'b0;
      end
    end
  end

  // Sticky error flags, set wins over reset switch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parFlag_r <= 1'b0;
      ctlFlag_r <= 1'b0;
    end else if (ce) begin
      parFlag_r <= (parFlag_r && !resetPulse_r) || parityErr;
      ctlFlag_r <= (ctlFlag_r && !resetPulse_r) || ctlErr;
    end
  end

  // ----------------------------------------------------------------
  // Panel latches and indicators
  // ----------------------------------------------------------------
  // Frozen latches keep the failing reference for the operator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frozen_r     <= 1'b0;
      latAddr_r[0] <= '0;
      latAddr_r[1] <= '0;
      latBuf_r[0]  <= '0;
      latBuf_r[1]  <= '0;
    end else if (ce) begin
      if (releasePulse_r) begin
        frozen_r <= 1'b0;
      end else if (ctrl_r[core_mem_pkg::F_FREEZE]) begin
        frozen_r <= 1'b1;
      end
      if (!frozen_r && state_r != core_mem_pkg::ST_IDLE) begin
        latAddr_r[curBank_r[1]] <= curAddr_r;
        latBuf_r[curBank_r[1]]  <= bufIn;
      end
    end
  end

  // All indicator and storage outputs come from flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dispAddr    <= '0;
      dispBuf     <= '0;
      banksInUse  <= 4'h0;
      portActive  <= '0;
      portReqLamp <= '0;
      memBank     <= 2'h0;
      memWrite    <= 1'b0;
      memAddr     <= '0;
    end else if (ce) begin
      dispAddr    <= latAddr_r[ctrl_r[core_mem_pkg::F_DISPSEL]];
      dispBuf     <= latBuf_r[ctrl_r[core_mem_pkg::F_DISPSEL]];
      banksInUse  <= bankEn;
      portActive  <= (state_r == core_mem_pkg::ST_IDLE) ? '0
                     : NP'(1) << curPort_r;
      portReqLamp <= portReq & selMask;
      memBank     <= curBank_r;
      memWrite    <= curWrite_r;
      memAddr     <= curAddr_r;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state; unmapped reads return zero, writes are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbAck          <= 1'b0;
      wbDatO         <= 32'h0;
      ctrl_r         <= core_mem_pkg::CTRL_RST;
      portCfg_r      <= core_mem_pkg::PORTCFG_RST;
      resetPulse_r   <= 1'b0;
      releasePulse_r <= 1'b0;
    end else if (ce) begin
      wbAck          <= wbReq;
      resetPulse_r   <= 1'b0;
      releasePulse_r <= 1'b0;
      wbDatO         <= 32'h0;
      if (wbReq && wbWe && wbAdr == core_mem_pkg::REG_CTRL) begin
        ctrl_r <= laneMerge(ctrl_r, wbDatI, wbSel) &
                  ~(32'h1 << core_mem_pkg::F_RESETSW) &
                  ~(32'h1 << core_mem_pkg::F_RELEASE);
        resetPulse_r   <= wbSel[0] && wbDatI[core_mem_pkg::F_RESETSW];
        releasePulse_r <= wbSel[0] && wbDatI[core_mem_pkg::F_RELEASE];
      end
      if (wbReq && wbWe && wbAdr == core_mem_pkg::REG_PORTCFG) begin
        portCfg_r <= laneMerge(portCfg_r, wbDatI, wbSel) & 32'hffff;
      end
      if (wbReq && !wbWe) begin
        case (wbAdr)
          core_mem_pkg::REG_CTRL:     wbDatO <= ctrl_r;
          core_mem_pkg::REG_PORTCFG:  wbDatO <= portCfg_r;
          core_mem_pkg::REG_STATUS:   wbDatO <= {21'h0, bankEn, frozen_r,
                                        ctlFlag_r, parFlag_r, stop_r,
                                        incFlag_r, 2'(state_r)};
          core_mem_pkg::REG_DISPADDR: wbDatO <= 32'(dispAddr);
          core_mem_pkg::REG_PORTSTAT: wbDatO <= {16'h0, portReqLamp, portActive};
          default:                    wbDatO <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_halted;
    ce && state_r == core_mem_pkg::ST_HALT;
  endsequence
  sequence s_released;
    s_halted ##0 resetPulse_r;
  endsequence

  property p_oneAck;
    @(posedge clk) disable iff (!resetn) $onehot0(portAck);
  endproperty
  a_oneAck: assert property (p_oneAck) else $error("two acks");

  property p_localQuiet;
    @(posedge clk) disable iff (!resetn)
      ce && ctrl_r[core_mem_pkg::F_LOCAL] |=> portAck == '0;
  endproperty
  a_localQuiet: assert property (p_localQuiet) else $error("local ack");

  property p_haltQuiet;
    @(posedge clk) disable iff (!resetn) s_halted |=> portAck == '0;
  endproperty
  a_haltQuiet: assert property (p_haltQuiet) else $error("ack halted");

  property p_release;
    @(posedge clk) disable iff (!resetn)
      s_released |=> state_r == core_mem_pkg::ST_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("no release");

  property p_deselQuiet;
    @(posedge clk) disable iff (!resetn) ce |=> (portAck & ~$past(selMask)) == '0;
  endproperty
  a_deselQuiet: assert property (p_deselQuiet) else $error("desel ack");

  property p_ringPass;
    @(posedge clk) disable iff (!resetn)
      ce && portAck[4] && $past(ringTop_r) == 2'h0 |-> ringTop_r == 2'h1;
  endproperty
  a_ringPass: assert property (p_ringPass) else $error("ring stuck");

  property p_pairFirst;
    @(posedge clk) disable iff (!resetn)
      ce && state_r == core_mem_pkg::ST_IDLE && elig[1:0] != 2'h0
      |=> portAck[NP-1:2] == '0;
  endproperty
  a_pairFirst: assert property (p_pairFirst) else $error("group order");

  property p_pairAlt;
    @(posedge clk) disable iff (!resetn) ce && portAck[0] |-> pairA_r;
  endproperty
  a_pairAlt: assert property (p_pairAlt) else $error("no alternation");

  property p_freezeHold;
    @(posedge clk) disable iff (!resetn)
      frozen_r && !releasePulse_r |=> $stable(latAddr_r[0]) && $stable(latAddr_r[1]);
  endproperty
  a_freezeHold: assert property (p_freezeHold) else $error("latch moved");

  // Read restart latency of the small variant, counted from the start pulse
  localparam int RD_LAT = (core_mem_pkg::CYC_SMALL_NS + core_mem_pkg::CLK_NS - 1)
                          / core_mem_pkg::CLK_NS;
  logic ceGap_r;

  // Enable went low since the last start; a frozen cycle may legally run long
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ceGap_r <= 1'b0;
    end else if (!ce) begin
      ceGap_r <= 1'b1;
    end else if (memStart != 2'h0) begin
      ceGap_r <= 1'b0;
    end
  end

  sequence s_readStart;
    ce && memStart != 2'h0 && !curWrite_r && !ctrl_r[core_mem_pkg::F_SINGLE]
    && !ctrl_r[core_mem_pkg::F_ERRSTOP] && !ctrl_r[core_mem_pkg::F_BIG];
  endsequence

  property p_readLen;
    @(posedge clk) disable iff (!resetn)
      s_readStart |-> ##RD_LAT (ceGap_r || portRdDone != '0);
  endproperty
  a_readLen: assert property (p_readLen) else $error("cycle length");

endmodule

// ### rtl/core_mem_pkg.sv
// Shared constants and types for the multiport core memory control block
package core_mem_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WRWAIT, ST_CYCLE, ST_HALT} state_t;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPORTS = 8;
  localparam int ADDR_W = 22;
  localparam int BUF_W  = 36;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 20;
  localparam int CYC_SMALL_NS  = 1000;
  localparam int CYC_BIG_NS    = 1180;
  localparam int WR_TIMEOUT_NS = 8000;
  localparam logic [8:0] CYC_SMALL  = 9'((CYC_SMALL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] CYC_BIG    = 9'((CYC_BIG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] WR_TIMEOUT = 9'(WR_TIMEOUT_NS / CLK_NS);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_PORTCFG  = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_DISPADDR = 8'h0c;
  localparam logic [7:0] REG_PORTSTAT = 8'h10;
  localparam logic [31:0] CTRL_RST    = 32'h0;
  localparam logic [31:0] PORTCFG_RST = 32'haaaa;

  // Control register fields
  localparam int F_ERRSTOP = 0;
  localparam int F_SINGLE  = 1;
  localparam int F_RESETSW = 2;
  localparam int F_DISPSEL = 3;
  localparam int F_FREEZE  = 4;
  localparam int F_RELEASE = 5;
  localparam int F_LOCAL   = 6;
  localparam int F_INTL35  = 7;
  localparam int F_INTL34  = 8;
  localparam int F_BIG     = 9;
  localparam int F_ONEMOD  = 10;
  localparam int F_BANKDES = 11;
  localparam int F_MEMNUM  = 16;

  // Port configuration codes, two bits per port
  localparam logic [1:0] CFG_DESEL = 2'h0;
  localparam logic [1:0] CFG_SHORT = 2'h1;
  localparam logic [1:0] CFG_LONG  = 2'h2;

  // Address vector index = 35 - documented bit number
  localparam int IX_B35 = 0;
  localparam int IX_B20 = 15;
  localparam int IX_B19 = 16;
  localparam int IX_B18 = 17;
  localparam int IX_B14 = 21;

endpackage

// ### dv/proc_port_model.sv
// Processor model on the eight memory bus ports
`timescale 1ns/100ps
module proc_port_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Bench control
  input  wire logic [7:0] want,
  input  wire logic [7:0] wr,
  input  wire logic [7:0] slow,
  // Port side
  output logic      [7:0] portReq,
  output logic      [7:0] portWrite,
  output logic      [7:0] portWrRestart,
  input  wire logic [7:0] portAck
);
  logic [7:0] served_r;
  logic [7:0] pend_r;
  // Request held to the ack edge; a slow port never sends write data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      served_r      <= '0;
      pend_r        <= '0;
      portWrRestart <= '0;
    end else begin
      served_r      <= (served_r | portAck) & want;
      pend_r        <= (pend_r | (portAck & wr)) & ~portWrRestart & want;
      portWrRestart <= pend_r & ~slow & ~portWrRestart;
    end
  end
  assign portReq   = want & ~served_r;
  assign portWrite = wr & portReq;
endmodule

// ### dv/tb_multiport_core_memory_control.sv
// Bench for port arbitration, cycle timing, error stop and setup
`timescale 1ns/100ps
module tb_multiport_core_memory_control;
  logic clk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
  logic [7:0] wbAdr = '0, want = '0, wr = '0, slow = '0;
  logic [7:0] portReq, portWrite, portWrRestart, portAck, portRdDone;
  logic [31:0] wbDatI = '0, wbDatO, rnd = 32'h5f, rd;
  logic [175:0] portAddr = '0;
  logic [35:0] bufIn = '0;
  logic [21:0] ea = '0;
  logic [1:0] memStart, memBank;
  logic [3:0] banksInUse;
  logic [21:0] memAddr, dispAddr;
  logic memWrite;
  logic [7:0] portActive;
  int bad_count = 0, cmp_count = 0, t = 0, e = 0;
  int expq[$];

  multiport_core_memory_control dut_u (.clk(clk), .resetn(resetn), .ce(1'b1),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hf),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .portReq(portReq),
    .portWrite(portWrite), .portWrRestart(portWrRestart), .portAddr(portAddr),
    .portAck(portAck), .portRdDone(portRdDone), .parityErr(1'b0), .ctlErr(1'b0),
    .bufIn(bufIn), .memStart(memStart), .memBank(memBank), .memWrite(memWrite),
    .memAddr(memAddr), .dispAddr(dispAddr), .dispBuf(), .banksInUse(banksInUse),
    .portActive(portActive), .portReqLamp());
  proc_port_model proc_u (.clk(clk), .resetn(resetn), .want(want), .wr(wr),
    .slow(slow), .portReq(portReq), .portWrite(portWrite),
    .portWrRestart(portWrRestart), .portAck(portAck));

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Classic single cycle; waits for ack, bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge clk);
    while (wbAck !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (wbAck !== 1'b1) bad_count++;
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  // Note the expected grant order (nibbles, f = none), then raise requests
  task automatic batch(input logic [7:0] m, w, input logic [15:0] o, input logic [3:0] hi);
    int k;
    for (k = 0; k < 4; k++) if (o[k*4+:4] != 4'hf) expq.push_back(o[k*4+:4]);
    for (k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      portAddr[k*22+:22] <= {hi, 3'h0, rnd[14:0]};
    end
    bufIn <= {4'h0, rnd};
    want <= m;
    wr <= w;
    k = 0;
    while (k < 900 && !(expq.size() == 0 && k > 60)) begin
      @(posedge clk);
      k++;
    end
    chk(32'(expq.size()), 0);
    want <= '0;
    @(posedge clk);
  endtask

  // Watcher: each grant takes the oldest note; read end timed from grant
  always @(posedge clk) begin
    t++;
    if (resetn && portAck !== 8'h00) begin
      e = expq.size() ? expq.pop_front() : 8;
      chk({24'h0, portAck}, 32'(9'h1 << e));
      chk(32'(memStart), {31'h0, !wr[e[2:0]]});
      ea = portAddr[e[2:0]*22 +: 22];
      t = 0;
    end
    if (resetn && portRdDone !== 8'h00) begin
      chk({t[23:0], portRdDone}, {24'(core_mem_pkg::CYC_SMALL), 8'(9'h1 << e)});
      chk({20'h0, banksInUse, portActive}, {20'h0, 4'hf, 8'(9'h1 << e)});
      chk({7'h0, memBank, memWrite, memAddr}, {10'h0, ea});
      chk({10'h0, dispAddr}, {10'h0, ea});
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    wb(0, core_mem_pkg::REG_PORTCFG, 0);
    chk(rd, core_mem_pkg::PORTCFG_RST);
    wb(0, 8'hfc, 0);
    chk(rd, 0);
    batch(8'h01, 0, 16'hfff0, 0);
    batch(8'h03, 0, 16'hff01, 0);
    batch(8'h10, 0, 16'hfff4, 0);
    batch(8'h90, 0, 16'hff47, 0);
    batch(8'h15, 0, 16'hf420, 0);
    batch(8'h08, 8'h08, 16'hfff3, 0);
    wb(1, core_mem_pkg::REG_PORTCFG, 32'haaa6);
    batch(8'h02, 0, 16'hfff1, 4'hf);
    batch(8'h01, 0, 16'hffff, 4'hf);
    wb(1, core_mem_pkg::REG_PORTCFG, 32'haaa4);
    batch(8'h01, 0, 16'hffff, 0);
    wb(1, core_mem_pkg::REG_CTRL, 32'h40);
    batch(8'h02, 0, 16'hffff, 0);
    wb(1, core_mem_pkg::REG_CTRL, 0);
    slow <= 8'h08;
    batch(8'h08, 8'h08, 16'hfff3, 0);
    batch(8'h04, 0, 16'hfff2, 0);
    wb(1, core_mem_pkg::REG_CTRL, 32'h1);
    batch(8'h08, 8'h08, 16'hfff3, 0);
    repeat (400) @(posedge clk);
    batch(8'h04, 0, 16'hffff, 0);
    wb(0, core_mem_pkg::REG_STATUS, 0);
    chk({29'h0, rd[2:0]}, 32'h7);
    wb(1, core_mem_pkg::REG_CTRL, 32'h5);
    slow <= 8'h00;
    batch(8'h04, 0, 16'hfff2, 0);
    stop_test();
  end

  // Hang guard, well past the longest expected run
  initial begin
    #(20 * 60000);
    bad_count++;
    stop_test();
  end
endmodule
